/* common/tcc_pkg.sv */
// shared constants and types for the timer channel output control block
package tcc_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned DIV_W = 15;
  // register indices on the plain register port
  localparam logic [3:0] REG_MODE = 4'h0;
  localparam logic [3:0] REG_CMP = 4'h1;
  localparam logic [3:0] REG_TOM = 4'h2;
  localparam logic [3:0] REG_TOL = 4'h3;
  localparam logic [3:0] REG_TO = 4'h4;
  localparam logic [3:0] REG_TOE = 4'h5;
  localparam logic [3:0] REG_POM = 4'h6;
  localparam logic [3:0] REG_PMC = 4'h7;
  localparam logic [3:0] REG_PLAT = 4'h8;
  localparam logic [3:0] REG_PDIR = 4'h9;
  localparam logic [3:0] REG_CTRL = 4'hA;
  localparam logic [3:0] REG_CNT = 4'hB;
  localparam logic [3:0] REG_STAT = 4'hC;
  // field positions
  localparam int unsigned CH1_BIT = 1;
  localparam int unsigned PIN0_BIT = 0;
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_STOP_BIT = 1;
  localparam int unsigned CTRL_PRS_LSB = 4;
  localparam int unsigned STAT_RUN_BIT = 0;
  localparam int unsigned STAT_BUSY_BIT = 1;
  localparam int unsigned STAT_PIN_BIT = 2;
  localparam int unsigned STAT_TI_BIT = 3;
  // implemented bits of the mode register
  localparam logic [15:0] MODE_MASK = 16'hD7CF;
  // values after reset
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] CMP_RST = 16'h0000;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic BIT_RST = 1'b0;
  localparam logic [3:0] PRS_RST = 4'h0;
  // upper three mode bits
  localparam logic [2:0] MD_INTERVAL = 3'h0;
  localparam logic [2:0] MD_CAPTURE = 3'h2;
  localparam logic [2:0] MD_EVENT = 3'h3;
  localparam logic [2:0] MD_ONECOUNT = 3'h4;
  localparam logic [2:0] MD_CAPONE = 3'h6;
  // trigger source and edge codes
  localparam logic [2:0] STS_EDGE = 3'h1;
  localparam logic [2:0] STS_BOTH = 3'h2;
  localparam logic [1:0] CIS_FALL = 2'h0;
  localparam logic [1:0] CIS_RISE = 2'h1;
  localparam logic [1:0] CIS_LOW_W = 2'h2;
  localparam logic [1:0] CIS_HIGH_W = 2'h3;

  typedef struct packed {
    logic [1:0] cks;
    logic z13;
    logic ccs;
    logic z11;
    logic [2:0] sts;
    logic [1:0] cis;
    logic [1:0] z5;
    logic [3:0] md;
  } tcc_mode_cfg_t;

  typedef enum {
    OP_IDLE,
    OP_INTERVAL,
    OP_CAPTURE,
    OP_EVENT,
    OP_ONECOUNT,
    OP_CAPONE
  } tcc_op_t;
endpackage

/* rtl/tcc_channel.sv */
// timer channel 1 with output path and port pin control
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/100ps
module tcc_channel (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic ch1_timer_input,
  input wire logic pin_in,
  output logic ch1_timer_interrupt,
  output logic pin_out,
  output logic pin_oe,
  output logic pin_analog_en
);
  tcc_pkg::tcc_mode_cfg_t mode_cfg;
  tcc_pkg::tcc_op_t op;
  logic [15:0] cmp_data;
  logic [15:0] channel_counter;
  logic [15:0] next_cnt;
  logic ch1_master_slave_bit;
  logic ch1_polarity_bit;
  logic ch1_output_value_bit;
  logic ch1_output_enable_bit;
  logic pin_open_drain_bit;
  logic pin_analog_bit;
  logic pin_latch_bit;
  logic pin_direction_bit;
  logic [3:0] prs_sel;
  logic [14:0] div_cnt;
  logic [14:0] prs_mask;
  logic run;
  logic busy;
  logic next_busy;
  logic ti_s1;
  logic ti_s2;
  logic ti_d;
  logic pin_s1;
  logic pin_s2;
  logic rise;
  logic fall;
  logic valid_edge;
  logic cap_start;
  logic cap_end;
  logic tick_mck;
  logic count_tick;
  logic start_cmd;
  logic stop_cmd;
  logic start_evt;
  logic in_trig;
  logic os_trig;
  logic irq_evt;
  logic cap_evt;
  logic out_tgl;
  logic out_act;
  logic out_inact;
  logic pin_level;
  logic md0;
  logic [15:0] rd_mux;

  assign md0 = mode_cfg.md[0];
  assign start_cmd = reg_wr && reg_addr == tcc_pkg::REG_CTRL
    && reg_wdata[tcc_pkg::CTRL_START_BIT];
  assign stop_cmd = reg_wr && reg_addr == tcc_pkg::REG_CTRL
    && reg_wdata[tcc_pkg::CTRL_STOP_BIT];
  assign start_evt = start_cmd && !run;

  // prescaler: one-cycle tick every 2^prs_sel core clocks
  assign prs_mask = 15'((32'h1 << prs_sel) - 32'h1);
  assign tick_mck = (div_cnt & prs_mask) == prs_mask;

  always_ff @(posedge core_clk)
  begin
    if (srst)
      div_cnt <= '0;
    else
      div_cnt <= div_cnt + 15'h1;
  end

  // pins from outside pass two flops before any logic sees them
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      ti_s1 <= 1'b0;
      ti_s2 <= 1'b0;
      ti_d <= 1'b0;
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
    end
    else
    begin
      ti_s1 <= ch1_timer_input;
      ti_s2 <= ti_s1;
      ti_d <= ti_s2;
      pin_s1 <= pin_in;
      pin_s2 <= pin_s1;
    end
  end

  assign rise = ti_s2 && !ti_d;
  assign fall = !ti_s2 && ti_d;

  always_comb
  begin
    case (mode_cfg.cis)
      tcc_pkg::CIS_FALL: valid_edge = fall;
      tcc_pkg::CIS_RISE: valid_edge = rise;
      default: valid_edge = rise || fall;
    endcase
  end

  // width measurement: start and capture on opposite edges
  assign cap_start = mode_cfg.cis == tcc_pkg::CIS_LOW_W ? fall :
    (mode_cfg.cis == tcc_pkg::CIS_HIGH_W ? rise : valid_edge);
  assign cap_end = mode_cfg.cis == tcc_pkg::CIS_LOW_W ? rise :
    (mode_cfg.cis == tcc_pkg::CIS_HIGH_W ? fall : valid_edge);
  assign count_tick = mode_cfg.ccs ? valid_edge : tick_mck;
  assign in_trig = run && ((mode_cfg.sts == tcc_pkg::STS_EDGE && valid_edge)
    || (mode_cfg.sts == tcc_pkg::STS_BOTH && (rise || fall)));
  assign os_trig = start_cmd || in_trig;

  // prohibited codes leave the channel idle
  always_comb
  begin
    case (mode_cfg.md[3:1])
      tcc_pkg::MD_INTERVAL: op = tcc_pkg::OP_INTERVAL;
      tcc_pkg::MD_CAPTURE: op = tcc_pkg::OP_CAPTURE;
      tcc_pkg::MD_EVENT: op = tcc_pkg::OP_EVENT;
      tcc_pkg::MD_ONECOUNT: op = tcc_pkg::OP_ONECOUNT;
      tcc_pkg::MD_CAPONE: op = md0 ? tcc_pkg::OP_IDLE : tcc_pkg::OP_CAPONE;
      default: op = tcc_pkg::OP_IDLE;
    endcase
  end

  always_comb
  begin
    next_cnt = channel_counter;
    next_busy = busy;
    irq_evt = 1'b0;
    cap_evt = 1'b0;
    out_tgl = 1'b0;
    out_act = 1'b0;
    out_inact = 1'b0;
    case (op)
      tcc_pkg::OP_INTERVAL:
      begin
        if (start_evt)
        begin
          next_cnt = cmp_data;
          irq_evt = md0;
          out_tgl = md0;
        end
        else if (run && count_tick)
        begin
          if (channel_counter == 16'h0000)
          begin
            next_cnt = cmp_data;
            irq_evt = 1'b1;
            out_tgl = 1'b1;
          end
          else
            next_cnt = channel_counter - 16'h0001;
        end
      end
      tcc_pkg::OP_CAPTURE:
      begin
        if (start_evt)
        begin
          next_cnt = 16'h0000;
          irq_evt = md0;
          out_tgl = md0;
        end
        else if (run && valid_edge)
        begin
          cap_evt = 1'b1;
          irq_evt = 1'b1;
          next_cnt = 16'h0000;
        end
        else if (run && count_tick)
          next_cnt = channel_counter + 16'h0001;
      end
      tcc_pkg::OP_EVENT:
      begin
        // start is silent whatever the low bit holds
        if (start_evt)
          next_cnt = cmp_data;
        else if (run && valid_edge)
        begin
          if (channel_counter == 16'h0000)
          begin
            next_cnt = cmp_data;
            irq_evt = 1'b1;
            out_tgl = 1'b1;
          end
          else
            next_cnt = channel_counter - 16'h0001;
        end
      end
      tcc_pkg::OP_ONECOUNT:
      begin
        if (os_trig && (!busy || md0))
        begin
          next_cnt = cmp_data;
          next_busy = 1'b1;
          irq_evt = busy;
          out_tgl = busy;
          out_act = 1'b1;
        end
        else if (busy && count_tick)
        begin
          if (channel_counter == 16'h0000)
          begin
            next_busy = 1'b0;
            irq_evt = 1'b1;
            out_tgl = 1'b1;
            out_inact = 1'b1;
          end
          else
            next_cnt = channel_counter - 16'h0001;
        end
      end
      tcc_pkg::OP_CAPONE:
      begin
        // start edges while busy are dropped on purpose
        if (run && !busy && cap_start)
        begin
          next_cnt = 16'h0000;
          next_busy = 1'b1;
        end
        else if (busy && cap_end)
        begin
          cap_evt = 1'b1;
          irq_evt = 1'b1;
          next_busy = 1'b0;
        end
        else if (busy && count_tick)
          next_cnt = channel_counter + 16'h0001;
      end
      default:
      begin
        next_cnt = channel_counter;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      run <= 1'b0;
      busy <= 1'b0;
      channel_counter <= tcc_pkg::CNT_RST;
    end
    else if (stop_cmd)
    begin
      run <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      run <= run || start_cmd;
      busy <= next_busy;
      channel_counter <= next_cnt;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      ch1_timer_interrupt <= 1'b0;
    else
      ch1_timer_interrupt <= irq_evt && !stop_cmd;
  end

  // captured count lands in the compare register; capture beats a write
  always_ff @(posedge core_clk)
  begin
    if (srst)
      cmp_data <= tcc_pkg::CMP_RST;
    else if (cap_evt && !stop_cmd)
      cmp_data <= channel_counter;
    else if (reg_wr && reg_addr == tcc_pkg::REG_CMP)
      cmp_data <= reg_wdata;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      mode_cfg <= tcc_pkg::MODE_RST;
      ch1_master_slave_bit <= tcc_pkg::BIT_RST;
      ch1_polarity_bit <= tcc_pkg::BIT_RST;
      ch1_output_enable_bit <= tcc_pkg::BIT_RST;
      pin_open_drain_bit <= tcc_pkg::BIT_RST;
      pin_analog_bit <= tcc_pkg::BIT_RST;
      pin_latch_bit <= tcc_pkg::BIT_RST;
      pin_direction_bit <= tcc_pkg::BIT_RST;
      prs_sel <= tcc_pkg::PRS_RST;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        tcc_pkg::REG_MODE: mode_cfg <= reg_wdata & tcc_pkg::MODE_MASK;
        tcc_pkg::REG_TOM: ch1_master_slave_bit <= reg_wdata[tcc_pkg::CH1_BIT];
        tcc_pkg::REG_TOL: ch1_polarity_bit <= reg_wdata[tcc_pkg::CH1_BIT];
        tcc_pkg::REG_TOE: ch1_output_enable_bit <= reg_wdata[tcc_pkg::CH1_BIT];
        tcc_pkg::REG_POM: pin_open_drain_bit <= reg_wdata[tcc_pkg::PIN0_BIT];
        tcc_pkg::REG_PMC: pin_analog_bit <= reg_wdata[tcc_pkg::PIN0_BIT];
        tcc_pkg::REG_PLAT: pin_latch_bit <= reg_wdata[tcc_pkg::PIN0_BIT];
        tcc_pkg::REG_PDIR: pin_direction_bit <= reg_wdata[tcc_pkg::PIN0_BIT];
        tcc_pkg::REG_CTRL: prs_sel <= reg_wdata[tcc_pkg::CTRL_PRS_LSB +: 4];
        default: prs_sel <= prs_sel;
      endcase
    end
  end

  // timer owns the output bit while enabled; software owns it otherwise
  always_ff @(posedge core_clk)
  begin
    if (srst)
      ch1_output_value_bit <= tcc_pkg::BIT_RST;
    else if (ch1_output_enable_bit)
    begin
      if (stop_cmd)
        ch1_output_value_bit <= ch1_output_value_bit;
      else if (ch1_master_slave_bit && out_act)
        ch1_output_value_bit <= !ch1_polarity_bit;
      else if (ch1_master_slave_bit && out_inact)
        ch1_output_value_bit <= ch1_polarity_bit;
      else if (!ch1_master_slave_bit && out_tgl)
        ch1_output_value_bit <= !ch1_output_value_bit;
    end
    else if (reg_wr && reg_addr == tcc_pkg::REG_TO)
      ch1_output_value_bit <= reg_wdata[tcc_pkg::CH1_BIT];
  end

  // latch and timer output are combined so either can own the pin
  assign pin_level = pin_latch_bit || ch1_output_value_bit;

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
      pin_analog_en <= 1'b0;
    end
    else
    begin
      pin_out <= pin_level;
      pin_oe <= !pin_analog_bit && !pin_direction_bit
        && (!pin_open_drain_bit || !pin_level);
      pin_analog_en <= pin_analog_bit;
    end
  end

  always_comb
  begin
    rd_mux = 16'h0000;
    case (reg_addr)
      tcc_pkg::REG_MODE: rd_mux = mode_cfg;
      tcc_pkg::REG_CMP: rd_mux = cmp_data;
      tcc_pkg::REG_TOM: rd_mux[tcc_pkg::CH1_BIT] = ch1_master_slave_bit;
      tcc_pkg::REG_TOL: rd_mux[tcc_pkg::CH1_BIT] = ch1_polarity_bit;
      tcc_pkg::REG_TO: rd_mux[tcc_pkg::CH1_BIT] = ch1_output_value_bit;
      tcc_pkg::REG_TOE: rd_mux[tcc_pkg::CH1_BIT] = ch1_output_enable_bit;
      tcc_pkg::REG_POM: rd_mux[tcc_pkg::PIN0_BIT] = pin_open_drain_bit;
      tcc_pkg::REG_PMC: rd_mux[tcc_pkg::PIN0_BIT] = pin_analog_bit;
      tcc_pkg::REG_PLAT: rd_mux[tcc_pkg::PIN0_BIT] = pin_latch_bit;
      tcc_pkg::REG_PDIR: rd_mux[tcc_pkg::PIN0_BIT] = pin_direction_bit;
      tcc_pkg::REG_CTRL: rd_mux[tcc_pkg::CTRL_PRS_LSB +: 4] = prs_sel;
      tcc_pkg::REG_CNT: rd_mux = channel_counter;
      tcc_pkg::REG_STAT:
      begin
        rd_mux[tcc_pkg::STAT_RUN_BIT] = run;
        rd_mux[tcc_pkg::STAT_BUSY_BIT] = busy;
        rd_mux[tcc_pkg::STAT_PIN_BIT] = pin_s2 && !pin_analog_bit;
        rd_mux[tcc_pkg::STAT_TI_BIT] = ti_s2;
      end
      default: rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
      reg_rdata <= rd_mux;
    else
      reg_rdata <= 16'h0000;
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  chk_interval_reload: assert property (
    op == tcc_pkg::OP_INTERVAL && run && count_tick && channel_counter == 16'h0000
      && !start_cmd && !stop_cmd
    |=> channel_counter == $past(cmp_data) && ch1_timer_interrupt)
    else $error("interval reload or interrupt missing");

  chk_interval_count: assert property (
    op == tcc_pkg::OP_INTERVAL && run && count_tick && channel_counter != 16'h0000
      && !stop_cmd && !reg_wr
    |=> channel_counter == $past(channel_counter) - 16'h0001 && !ch1_timer_interrupt)
    else $error("interval count down wrong");

  chk_start_irq: assert property (
    (op == tcc_pkg::OP_INTERVAL || op == tcc_pkg::OP_CAPTURE) && start_evt && !stop_cmd
    |=> ch1_timer_interrupt == $past(md0))
    else $error("start interrupt does not follow low mode bit");

  chk_onecount_ignore: assert property (
    op == tcc_pkg::OP_ONECOUNT && busy && !md0 && os_trig && !stop_cmd
      && !(count_tick && channel_counter == 16'h0000)
    |=> !ch1_timer_interrupt && channel_counter
      == $past(channel_counter) - ($past(count_tick) ? 16'h0001 : 16'h0000))
    else $error("one-count retrigger not ignored");

  chk_onecount_retrig: assert property (
    op == tcc_pkg::OP_ONECOUNT && busy && md0 && os_trig && !stop_cmd
    |=> ch1_timer_interrupt && channel_counter == $past(cmp_data))
    else $error("one-count retrigger not accepted");

  chk_capone_start: assert property (
    op == tcc_pkg::OP_CAPONE && run && !busy && cap_start && !stop_cmd
    |=> busy && !ch1_timer_interrupt ##1 !ch1_timer_interrupt || !busy)
    else $error("capture one-count start raised interrupt");

  chk_capone_capture: assert property (
    op == tcc_pkg::OP_CAPONE && busy && cap_end && !stop_cmd
    |=> cmp_data == $past(channel_counter) && !busy && ch1_timer_interrupt)
    else $error("width capture wrong");

  chk_edge_rise: assert property (
    op == tcc_pkg::OP_CAPTURE && run && !start_cmd && !stop_cmd && rise
      && mode_cfg.cis == tcc_pkg::CIS_RISE
    |=> ch1_timer_interrupt && channel_counter == 16'h0000)
    else $error("rising edge capture missed");

  chk_out_locked: assert property (
    ch1_output_enable_bit && reg_wr && reg_addr == tcc_pkg::REG_TO
      && !out_tgl && !out_act && !out_inact
    |=> $stable(ch1_output_value_bit))
    else $error("write reached output bit while enabled");

  chk_out_written: assert property (
    !ch1_output_enable_bit && reg_wr && reg_addr == tcc_pkg::REG_TO
    |=> ch1_output_value_bit == $past(reg_wdata[tcc_pkg::CH1_BIT])
      ##1 pin_out == ($past(ch1_output_value_bit) || $past(pin_latch_bit)))
    else $error("software output write lost");

  chk_slave_set: assert property (
    ch1_output_enable_bit && ch1_master_slave_bit && out_act && !stop_cmd
    |=> ch1_output_value_bit == !$past(ch1_polarity_bit))
    else $error("slave output not set to active level");

  chk_pin_drive: assert property (
    1'b1 |=> pin_oe == (!$past(pin_analog_bit) && !$past(pin_direction_bit)
      && (!$past(pin_open_drain_bit) || !pin_out)))
    else $error("pin drive enable wrong");

  cov_interval_irq: cover property (op == tcc_pkg::OP_INTERVAL ##1 ch1_timer_interrupt);
  cov_onecount_end: cover property (op == tcc_pkg::OP_ONECOUNT && busy ##1 !busy);
  cov_capone_meas: cover property (op == tcc_pkg::OP_CAPONE && cap_evt);
  cov_open_drain: cover property (pin_open_drain_bit && pin_oe);
endmodule

/* sim/tb.sv */
// self-checking bench for the timer channel output control block
`timescale 1ns/100ps
module tb;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic ch1_timer_input = 1'b0;
  logic pin_in = 1'b0;
  logic ch1_timer_interrupt;
  logic pin_out;
  logic pin_oe;
  logic pin_analog_en;
  int errors = 0;
  int cmp_count = 0;
  int c;
  int k;
  int n;
  logic [15:0] rv;
  logic [4:0] v;
  logic oe;
  logic [3:0] mode_list [5] = '{4'h6, 4'h2, 4'hA, 4'hE, 4'hF};

  always #4 core_clk = ~core_clk;

  tcc_channel tcc_channel_i (
    .core_clk(core_clk),
    .srst(srst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .ch1_timer_input(ch1_timer_input),
    .pin_in(pin_in),
    .ch1_timer_interrupt(ch1_timer_interrupt),
    .pin_out(pin_out),
    .pin_oe(pin_oe),
    .pin_analog_en(pin_analog_en)
  );

  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("FAIL at %0t: %s got %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // samples each cycle once, leaves on a clock edge
  task automatic count_irq(input int cyc, output int cnt);
    cnt = 0;
    repeat (cyc)
    begin
      #1;
      if (ch1_timer_interrupt === 1'b1)
        cnt++;
      @(posedge core_clk);
    end
  endtask

  task automatic wait_irq(input int maxc, output int cyc);
    cyc = 0;
    for (int i = 1; i <= maxc; i++)
    begin
      #1;
      if (ch1_timer_interrupt === 1'b1)
      begin
        cyc = i;
        break;
      end
      @(posedge core_clk);
    end
    if (cyc == 0)
    begin
      errors++;
      $display("FAIL at %0t: interrupt wait ran out", $time);
      wrap_up();
    end
    @(posedge core_clk);
  endtask

  function automatic logic [15:0] mask_of(input int a);
    case (a)
      0: return tcc_pkg::MODE_MASK;
      1: return 16'hFFFF;
      2, 3, 4, 5: return 16'h0002;
      6, 7, 8, 9: return 16'h0001;
      default: return 16'h0000;
    endcase
  endfunction

  initial
  begin
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    void'($urandom(80));
    for (int a = 0; a < 14; a++)
    begin
      rd(4'(a), rv);
      chk(rv, 16'h0000, "reset value");
    end
    // output enable stays 0 so the output value bit takes writes
    for (int a = 0; a < 14; a++)
    begin
      if (a == 5 || a == 10 || a == 11 || a == 12)
        continue;
      c = $urandom;
      wr(4'(a), 16'(c));
      rd(4'(a), rv);
      chk(rv, 16'(c) & mask_of(a), "read back");
    end
    $display("test registers done");

    for (int t = 0; t < 3; t++)
    begin
      c = 3 + $urandom_range(5);
      wr(tcc_pkg::REG_TOE, 16'h0000);
      wr(tcc_pkg::REG_TO, 16'h0000);
      wr(tcc_pkg::REG_TOE, 16'h0002);
      wr(tcc_pkg::REG_TOM, 16'h0000);
      wr(tcc_pkg::REG_CMP, 16'(c));
      wr(tcc_pkg::REG_MODE, (t == 2) ? 16'h0000 : 16'h0001);
      wr(tcc_pkg::REG_CTRL, (t == 1) ? 16'h0011 : 16'h0001);
      if (t == 2)
      begin
        count_irq(c + 1, k);
        chk(16'(k), 16'h0000, "no start irq");
      end
      wait_irq(1, n);
      for (int j = 0; j < 2; j++)
      begin
        wait_irq(80, n);
        if (j > 0 || t != 1)
          chk(16'(n), 16'((c + 1) << (t == 1)), "period");
      end
      wr(tcc_pkg::REG_CTRL, 16'h0002);
      rd(tcc_pkg::REG_TO, rv);
      chk(rv, 16'h0002, "three toggles");
      wr(tcc_pkg::REG_TO, 16'h0000);
      rd(tcc_pkg::REG_TO, rv);
      chk(rv, 16'h0002, "write ignored");
    end
    $display("test interval done");

    wr(tcc_pkg::REG_TOE, 16'h0000);
    for (int i = 0; i < 32; i++)
    begin
      v = 5'(i);
      wr(tcc_pkg::REG_PMC, {15'h0000, v[4]});
      wr(tcc_pkg::REG_PDIR, {15'h0000, v[3]});
      wr(tcc_pkg::REG_POM, {15'h0000, v[2]});
      wr(tcc_pkg::REG_PLAT, {15'h0000, v[1]});
      wr(tcc_pkg::REG_TO, {14'h0000, v[0], 1'b0});
      pin_in <= 1'($urandom);
      repeat (4) @(posedge core_clk);
      #1;
      oe = !v[4] && !v[3] && (!v[2] || !(v[1] | v[0]));
      chk(16'(pin_analog_en), 16'(v[4]), "analog select");
      chk(16'(pin_oe), 16'(oe), "pin drive");
      if (oe)
        chk(16'(pin_out), 16'(v[1] | v[0]), "pin level");
      rd(tcc_pkg::REG_STAT, rv);
      chk(16'(rv[2]), 16'(!v[4] & pin_in), "pin status");
    end
    $display("test pin done");

    for (int e = 0; e < 2; e++)
    begin
      ch1_timer_input <= 1'b0;
      wr(tcc_pkg::REG_MODE, {8'h00, 2'(e), 6'h04});
      wr(tcc_pkg::REG_CTRL, 16'h0001);
      ch1_timer_input <= 1'b1;
      count_irq(8, k);
      chk(16'(k), 16'(e == 1), "rising edge");
      ch1_timer_input <= 1'b0;
      count_irq(8, k);
      chk(16'(k), 16'(e == 0), "falling edge");
      wr(tcc_pkg::REG_CTRL, 16'h0002);
    end
    $display("test edge select done");

    // start and capture edges share the synchroniser, so width is exact to one tick
    for (int e = 2; e < 4; e++)
    begin
      ch1_timer_input <= (e == 2);
      wr(tcc_pkg::REG_MODE, {8'h00, 2'(e), 6'h0C});
      wr(tcc_pkg::REG_CTRL, 16'h0001);
      c = 5 + $urandom_range(20);
      ch1_timer_input <= (e != 2);
      count_irq(c, k);
      chk(16'(k), 16'h0000, "start edge quiet");
      ch1_timer_input <= (e == 2);
      wait_irq(8, n);
      rd(tcc_pkg::REG_CMP, rv);
      chk(16'(rv + 1 >= c && rv <= c + 1), 16'h0001, "width");
      wr(tcc_pkg::REG_CTRL, 16'h0002);
    end
    $display("test width done");

    for (int i = 0; i < 2; i++)
    begin
      ch1_timer_input <= 1'b0;
      wr(tcc_pkg::REG_TOE, 16'h0000);
      wr(tcc_pkg::REG_TO, 16'h0000);
      wr(tcc_pkg::REG_TOL, 16'(i << 1));
      wr(tcc_pkg::REG_TOM, 16'h0002);
      wr(tcc_pkg::REG_TOE, 16'h0002);
      wr(tcc_pkg::REG_CMP, 16'h0028);
      wr(tcc_pkg::REG_MODE, {5'h00, 3'h1, 2'h1, 2'h0, 4'(8 + i)});
      wr(tcc_pkg::REG_CTRL, 16'h0001);
      count_irq(4, k);
      chk(16'(k), 16'h0000, "idle trigger");
      rd(tcc_pkg::REG_TO, rv);
      chk(rv, (i == 0) ? 16'h0002 : 16'h0000, "slave start");
      ch1_timer_input <= 1'b1;
      count_irq(8, k);
      chk(16'(k), 16'(i), "retrigger");
      wait_irq(60, n);
      rd(tcc_pkg::REG_TO, rv);
      chk(rv, 16'(i << 1), "slave end");
      wr(tcc_pkg::REG_CTRL, 16'h0002);
    end
    $display("test one-count done");

    // event mode and prohibited codes must stay silent at start
    foreach (mode_list[m])
    begin
      wr(tcc_pkg::REG_CMP, 16'h0001);
      wr(tcc_pkg::REG_MODE, {12'h000, mode_list[m]});
      wr(tcc_pkg::REG_CTRL, 16'h0001);
      count_irq(10, k);
      chk(16'(k), 16'h0000, "silent mode");
      wr(tcc_pkg::REG_CTRL, 16'h0002);
    end
    $display("test mode codes done");

    // event mode, compare 1: first rising edge counts down, second reloads
    wr(tcc_pkg::REG_MODE, 16'h0046);
    wr(tcc_pkg::REG_CTRL, 16'h0001);
    for (int j = 0; j < 2; j++)
    begin
      ch1_timer_input <= 1'b0;
      count_irq(5, k);
      ch1_timer_input <= 1'b1;
      count_irq(5, k);
      chk(16'(k), 16'(j), "event count");
    end
    wr(tcc_pkg::REG_CTRL, 16'h0002);
    $display("test event count done");
    wrap_up();
  end
endmodule
